//--- logic/reset_brownout_map.vh
/*
  Constants of the reset and brownout sequencer: timing counts, widths and
  the boot fetch address. Assumes inclusion by the design files only.
*/
`ifndef RESET_BROWNOUT_MAP_VH
`define RESET_BROWNOUT_MAP_VH

// Oscillator rate in kHz and the clock period that follows from it
`define RBC_OSC_KHZ        4000
`define RBC_CLK_MHZ        250
// Wake-up count in oscillator cycles after the oscillator runs
`define RBC_WAKE_CYCLES    16'h0100
`define RBC_WAKE_WIDTH     16
// Brownout hysteresis filter length in clock cycles
`define RBC_HYST_CYCLES    8'h10
`define RBC_HYST_WIDTH     8
// Boot fetch address after reset release
`define RBC_BOOT_ADDR      32'h0000_0000
// Reset state of the block's status outputs
`define RBC_RST_LOW        1'b0

`endif

//--- logic/level_filter.v
/*
  Synchronises one asynchronous comparator level and applies hysteresis:
  the output changes only after the input has stood at the new level for
  a full count. Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "reset_brownout_map.vh"

module level_filter #(
  parameter             CNT_W   = `RBC_HYST_WIDTH,
  parameter [CNT_W-1:0] HOLD    = `RBC_HYST_CYCLES,
  parameter             INIT    = 1'b1
) (
  input  wire clk,
  input  wire arst_n,
  input  wire rawIn,
  output wire filtOut
);

  reg             sync1_ff;
  reg             sync2_ff;
  reg             sync3_ff;
  reg             out_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] nxt_cnt;
  reg             nxt_out;

  // Three flops; a change counts once the second and third agree
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= INIT;
      sync2_ff <= INIT;
      sync3_ff <= INIT;
    end else begin
      sync1_ff <= rawIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Must hold for HOLD cycles, so a noisy threshold does not chatter
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if ((sync2_ff != sync3_ff) || (sync3_ff == out_ff)) begin
      nxt_cnt = {CNT_W{1'b0}};
    end else if (cnt_ff == HOLD - 1'b1) begin
      nxt_out = sync3_ff;
      nxt_cnt = {CNT_W{1'b0}};
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= {CNT_W{1'b0}};
      out_ff <= INIT;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign filtOut = out_ff;

endmodule

//--- logic/reset_and_brownout_control.v
/*
  Reset and brownout sequencer: merges reset causes, runs the wake-up
  timer, drives the reset output pin, raises the brownout interrupt.
  Assumes clk is the internal RC oscillator rate and arst_n is the
  power-on detector output; all other inputs are asynchronous levels.
*/
// Behaviour
// - Pin reset, watchdog, power-on and brownout all merge into one chip reset.
// - Any reset cause drives the reset output pin low and restarts wake timer.
// - Internal reset holds until pin released, oscillator runs, count done, flash ready.
// - Reset output pin returns high after release; brownout waits for supply recovery.
// - After release the core fetches first from address zero.
// - All registers hold reset values when internal reset releases.
// - Brownout interrupt request raised while supply below 2.2 V.
// - Interrupt reaches core only if enabled; level always readable as status.
// - Chip reset asserted while supply below 1.85 V, protecting flash.
// - Brownout reset holds toward 1 V, then power-on reset takes over.
// - Both brownout thresholds are filtered with hysteresis against chatter.
// - After power-up the block runs from the 4 MHz internal RC oscillator.
`timescale 1ns/1ps
`include "reset_brownout_map.vh"

module reset_and_brownout_control #(
  parameter                 WAKE_W      = `RBC_WAKE_WIDTH,
  parameter [WAKE_W-1:0]    WAKE_CYCLES = `RBC_WAKE_CYCLES,
  parameter                 HYST_W      = `RBC_HYST_WIDTH,
  parameter [HYST_W-1:0]    HYST_CYCLES = `RBC_HYST_CYCLES
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        extResetIn_n,
  input  wire        watchdogResetReq,
  input  wire        supplyAboveIrqTh,
  input  wire        supplyAboveRstTh,
  input  wire        oscRunning,
  input  wire        flashInitDone,
  input  wire        brownoutIrqEnable,
  output reg         flashInitStart,
  output reg         coreReset_n,
  output reg  [31:0] bootFetchAddr,
  output reg         resetOutPin,
  output reg         resetOutPinOe_n,
  output reg         brownoutIrqReq,
  output reg         brownoutStatus
);

  localparam [1:0] ST_HOLD  = 2'b00;
  localparam [1:0] ST_WAKE  = 2'b01;
  localparam [1:0] ST_FLASH = 2'b10;
  localparam [1:0] ST_RUN   = 2'b11;

  wire irqAbove;
  wire rstAbove;
  reg               extS1_ff;
  reg               extS2_ff;
  reg               extS3_ff;
  reg               extLvl_ff;
  reg               wdS1_ff;
  reg               wdS2_ff;
  reg               wdS3_ff;
  reg               wdLvl_ff;
  reg               oscS1_ff;
  reg               oscS2_ff;
  reg               oscS3_ff;
  reg               oscLvl_ff;
  reg               flS1_ff;
  reg               flS2_ff;
  reg               flS3_ff;
  reg               flLvl_ff;
  reg               enS1_ff;
  reg               enS2_ff;
  reg               enS3_ff;
  reg               enLvl_ff;
  reg  [1:0]        state_ff;
  reg  [1:0]        nxt_state;
  reg  [WAKE_W-1:0] wake_ff;
  reg  [WAKE_W-1:0] nxt_wake;
  reg               anyCause;

  // One state decode for the reset, reset pin and flash-start outputs, so they cannot drift apart
  function inState;
    input [1:0] st;
    input [1:0] code;
    begin
      inState = (st == code);
    end
  endfunction

  // Hysteresis filters for both brownout stages
  level_filter #(.CNT_W(HYST_W), .HOLD(HYST_CYCLES), .INIT(1'b0)) irqFilt (
    .clk    (clk),
    .arst_n (arst_n),
    .rawIn  (supplyAboveIrqTh),
    .filtOut(irqAbove)
  );

  level_filter #(.CNT_W(HYST_W), .HOLD(HYST_CYCLES), .INIT(1'b0)) rstFilt (
    .clk    (clk),
    .arst_n (arst_n),
    .rawIn  (supplyAboveRstTh),
    .filtOut(rstAbove)
  );

  // Three-stage sync; a level moves once stages two and three agree
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {extS1_ff, extS2_ff, extS3_ff, extLvl_ff} <= 4'h0;
      {wdS1_ff, wdS2_ff, wdS3_ff, wdLvl_ff}     <= 4'h0;
      {oscS1_ff, oscS2_ff, oscS3_ff, oscLvl_ff} <= 4'h0;
      {flS1_ff, flS2_ff, flS3_ff, flLvl_ff}     <= 4'h0;
      {enS1_ff, enS2_ff, enS3_ff, enLvl_ff}     <= 4'h0;
    end else begin
      extS1_ff <= extResetIn_n;
      extS2_ff <= extS1_ff;
      extS3_ff <= extS2_ff;
      if (extS2_ff == extS3_ff) begin
        extLvl_ff <= extS3_ff;
      end
      wdS1_ff <= watchdogResetReq;
      wdS2_ff <= wdS1_ff;
      wdS3_ff <= wdS2_ff;
      if (wdS2_ff == wdS3_ff) begin
        wdLvl_ff <= wdS3_ff;
      end
      oscS1_ff <= oscRunning;
      oscS2_ff <= oscS1_ff;
      oscS3_ff <= oscS2_ff;
      if (oscS2_ff == oscS3_ff) begin
        oscLvl_ff <= oscS3_ff;
      end
      flS1_ff <= flashInitDone;
      flS2_ff <= flS1_ff;
      flS3_ff <= flS2_ff;
      if (flS2_ff == flS3_ff) begin
        flLvl_ff <= flS3_ff;
      end
      enS1_ff <= brownoutIrqEnable;
      enS2_ff <= enS1_ff;
      enS3_ff <= enS2_ff;
      if (enS2_ff == enS3_ff) begin
        enLvl_ff <= enS3_ff;
      end
    end
  end

  // Power-on below 1 V is arst_n itself; brownout covers the band above
  always @* begin
    anyCause = !extLvl_ff || wdLvl_ff || !rstAbove;
  end

  // Wake-up sequencer; clk is the RC oscillator, so counts are its cycles
  always @* begin
    nxt_state = state_ff;
    nxt_wake  = wake_ff;
    case (state_ff)
      ST_HOLD: begin
        nxt_wake = {WAKE_W{1'b0}};
        if (!anyCause && oscLvl_ff) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_ff == WAKE_CYCLES - 1'b1) begin
          nxt_state = ST_FLASH;
        end else begin
          nxt_wake = wake_ff + 1'b1;
        end
      end
      ST_FLASH: begin
        if (flLvl_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_HOLD;
      end
    endcase
    // Any cause restarts the whole sequence, including a lost oscillator
    if (anyCause || !oscLvl_ff) begin
      nxt_state = ST_HOLD;
      nxt_wake  = {WAKE_W{1'b0}};
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_HOLD;
      wake_ff  <= {WAKE_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      wake_ff  <= nxt_wake;
    end
  end

  // Outputs registered; reset output pin is driven, enable low
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coreReset_n     <= `RBC_RST_LOW;
      resetOutPin     <= `RBC_RST_LOW;
      resetOutPinOe_n <= 1'b0;
      flashInitStart  <= `RBC_RST_LOW;
      bootFetchAddr   <= `RBC_BOOT_ADDR;
      brownoutIrqReq  <= `RBC_RST_LOW;
      brownoutStatus  <= `RBC_RST_LOW;
    end else begin
      coreReset_n     <= inState(nxt_state, ST_RUN);
      resetOutPin     <= inState(nxt_state, ST_RUN);
      resetOutPinOe_n <= 1'b0;
      flashInitStart  <= inState(nxt_state, ST_FLASH);
      bootFetchAddr   <= `RBC_BOOT_ADDR;
      brownoutStatus  <= !irqAbove;
      brownoutIrqReq  <= !irqAbove && enLvl_ff;
    end
  end

  // Peripherals share coreReset_n, so all registers reset together

endmodule

//--- dv/flash_init_model.sv
/* Flash controller model: answers an init request after DELAY cycles.
   Assumes the sequencer's clock and power-on reset. */
`timescale 1ns/1ps
module flash_init_model #(
  parameter int DELAY = 6
) (
  input  wire  clk,
  input  wire  arst_n,
  input  wire  flashInitStart,
  input  wire  coreReset_n,
  output logic flashInitDone
);
  int cnt;
  // Done holds until the chip re-enters reset, as real flash does
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      flashInitDone <= 1'b0;
    end else if (flashInitStart && !flashInitDone) begin
      cnt <= cnt + 1;
      flashInitDone <= (cnt >= DELAY - 1);
    end else if (!flashInitStart) begin
      cnt <= 0;
      if (!coreReset_n) flashInitDone <= 1'b0;
    end
  end
endmodule

//--- dv/reset_and_brownout_control_properties.sv
/* Port relations of the reset sequencer.
   Assumes binding to the top module, one clock, active-low arst_n. */
`timescale 1ns/1ps
module reset_and_brownout_control_properties (
  input wire        clk,
  input wire        arst_n,
  input wire        extResetIn_n,
  input wire        watchdogResetReq,
  input wire        supplyAboveIrqTh,
  input wire        supplyAboveRstTh,
  input wire        oscRunning,
  input wire        flashInitStart,
  input wire        coreReset_n,
  input wire [31:0] bootFetchAddr,
  input wire        resetOutPin,
  input wire        resetOutPinOe_n,
  input wire        brownoutIrqReq,
  input wire        brownoutStatus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence pinHeld; !extResetIn_n [*3]; endsequence
  sequence dogHeld; watchdogResetReq [*3]; endsequence
  sequence oscLost; !oscRunning [*3]; endsequence
  // Sync latency plus one cycle
  sequence dropSoon; ##[1:6] !coreReset_n; endsequence
  a_pin_forces_reset: assert property (coreReset_n ##0 pinHeld |-> dropSoon)
    else $error("pin reset not taken");
  a_dog_forces_reset: assert property (coreReset_n ##0 dogHeld |-> dropSoon)
    else $error("watchdog reset not taken");
  a_osc_loss_reset: assert property (coreReset_n ##0 oscLost |-> dropSoon)
    else $error("oscillator loss not taken");
  a_low_supply_reset: assert property (coreReset_n ##0 !supplyAboveRstTh [*8]
    |-> ##[0:8] !coreReset_n)
    else $error("brownout reset not taken");
  a_pin_tracks_core: assert property (resetOutPin == coreReset_n)
    else $error("reset pin differs from chip reset");
  a_pin_driven: assert property (!resetOutPinOe_n)
    else $error("reset pin not driven");
  a_boot_addr_zero: assert property ($rose(coreReset_n) |-> bootFetchAddr == 32'h0000_0000)
    else $error("boot address not zero");
  a_flash_before_run: assert property ($rose(coreReset_n) |-> $past(flashInitStart))
    else $error("release without flash init");
  a_irq_needs_status: assert property (brownoutIrqReq |-> brownoutStatus)
    else $error("interrupt without status");
  a_status_raises: assert property (!supplyAboveIrqTh [*8] |-> ##[0:8] brownoutStatus)
    else $error("status not raised");
endmodule
bind reset_and_brownout_control reset_and_brownout_control_properties
  i_reset_and_brownout_control_properties (.clk(clk), .arst_n(arst_n),
  .extResetIn_n(extResetIn_n), .watchdogResetReq(watchdogResetReq),
  .supplyAboveIrqTh(supplyAboveIrqTh), .supplyAboveRstTh(supplyAboveRstTh),
  .oscRunning(oscRunning), .flashInitStart(flashInitStart), .coreReset_n(coreReset_n),
  .bootFetchAddr(bootFetchAddr), .resetOutPin(resetOutPin),
  .resetOutPinOe_n(resetOutPinOe_n), .brownoutIrqReq(brownoutIrqReq),
  .brownoutStatus(brownoutStatus));

//--- dv/reset_and_brownout_control_tb_top.sv
/* Testbench of the reset sequencer with a flash model.
   Assumes the design files on the include path; short counts. */
`timescale 1ns/1ps
module reset_and_brownout_control_tb_top;
  localparam int WAKE = 8;
  localparam int FDLY = 6;
  logic clk = 1'b0, arst_n = 1'b0, extResetIn_n = 1'b1, watchdogResetReq = 1'b0;
  logic supplyAboveIrqTh = 1'b1, supplyAboveRstTh = 1'b1, oscRunning = 1'b1;
  logic brownoutIrqEnable = 1'b0;
  wire flashInitDone, flashInitStart, coreReset_n, resetOutPin, resetOutPinOe_n;
  wire brownoutIrqReq, brownoutStatus;
  wire [31:0] bootFetchAddr;
  int err_total = 0, check_count = 0;
  always #2 clk = ~clk;
  reset_and_brownout_control #(.WAKE_CYCLES(16'h0008), .HYST_CYCLES(8'h04))
    i_reset_and_brownout_control (.clk(clk), .arst_n(arst_n),
    .extResetIn_n(extResetIn_n), .watchdogResetReq(watchdogResetReq),
    .supplyAboveIrqTh(supplyAboveIrqTh), .supplyAboveRstTh(supplyAboveRstTh),
    .oscRunning(oscRunning), .flashInitDone(flashInitDone),
    .brownoutIrqEnable(brownoutIrqEnable), .flashInitStart(flashInitStart),
    .coreReset_n(coreReset_n), .bootFetchAddr(bootFetchAddr), .resetOutPin(resetOutPin),
    .resetOutPinOe_n(resetOutPinOe_n), .brownoutIrqReq(brownoutIrqReq),
    .brownoutStatus(brownoutStatus));
  flash_init_model #(.DELAY(FDLY)) i_flash_init_model (.clk(clk), .arst_n(arst_n),
    .flashInitStart(flashInitStart), .coreReset_n(coreReset_n),
    .flashInitDone(flashInitDone));
  task checkBit(input string what, input logic expv, input logic got);
    check_count++;
    if (got !== expv) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", what, expv, got);
    end
  endtask
  task waitCore(output int n);
    n = 0;
    while (coreReset_n !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task bootSeq;
    int n;
    waitCore(n);
    checkBit("wakeLong", 1'b1, n >= WAKE + FDLY && n < 400);
    checkBit("resetOutPin", 1'b1, resetOutPin);
    checkBit("bootAddrZero", 1'b1, bootFetchAddr === 32'h0000_0000);
  endtask
  task irqTest;
    logic seen;
    seen = 1'b0;
    @(posedge clk) supplyAboveIrqTh <= 1'b0;
    // Two cycles, shorter than the filter count
    repeat (2) @(posedge clk);
    supplyAboveIrqTh <= 1'b1;
    // Watch every cycle, a short pulse would be gone by the end
    repeat (20) begin
      @(negedge clk);
      seen = seen | (brownoutStatus !== 1'b0);
    end
    checkBit("glitchStatus", 1'b0, seen);
    @(posedge clk) supplyAboveIrqTh <= 1'b0;
    repeat (20) @(negedge clk);
    checkBit("status", 1'b1, brownoutStatus);
    checkBit("irqMasked", 1'b0, brownoutIrqReq);
    checkBit("coreStays", 1'b1, coreReset_n);
    @(posedge clk) brownoutIrqEnable <= 1'b1;
    repeat (10) @(negedge clk);
    checkBit("irqEnabled", 1'b1, brownoutIrqReq);
    @(posedge clk) supplyAboveIrqTh <= 1'b1;
    repeat (20) @(negedge clk);
    checkBit("statusClear", 1'b0, brownoutStatus);
    checkBit("irqClear", 1'b0, brownoutIrqReq);
  endtask
  task causeTest(input int k);
    int n;
    @(posedge clk);
    case (k)
      0: extResetIn_n <= 1'b0;
      1: watchdogResetReq <= 1'b1;
      2: supplyAboveRstTh <= 1'b0;
      3: oscRunning <= 1'b0;
      default: arst_n <= 1'b0;
    endcase
    repeat (20) @(negedge clk);
    checkBit("coreReset_n", 1'b0, coreReset_n);
    checkBit("resetOutPinLow", 1'b0, resetOutPin);
    @(posedge clk) {extResetIn_n, watchdogResetReq, supplyAboveRstTh, oscRunning, arst_n} <= 5'h17;
    waitCore(n);
    checkBit("restarted", 1'b1, n >= WAKE + FDLY && n < 400);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    bootSeq();
    irqTest();
    for (int k = 0; k < 5; k++) causeTest(k);
    wrap_up();
  end
  // Run takes about 360 cycles
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule
